// [rtl/pcd_conduit_map.svh]
// Purpose: constants of the test and debug conduit: offsets, field positions,
//   reset values and timing counts.
// Assumes: 40 MHz core clock.
// Notes: included by the conduit module only; the package does not include it.
// Behaviour
// - Test bit 0 shortens the initialization counters to speed up simulation.
// - Test bit 2 high during initialization turns data scrambling off.
// - Test bit 5 high keeps training out of compliance mode; setting it sends compliance back to detect quiet.
// - Test bit 6 forces compliance when polling times out before every lane saw its exit.
// - Test bit 7 stops low-power link state negotiation.
// - The speed output reads 00 undefined, 01 first, 10 second, 11 third generation.
// - Board status bits 1:0 carry speed, bit 2 receive-buffer and bit 3 retry-buffer corrections.
// - Board status bits 4, 5, 7:6 and 8 carry internal, receive, transmit and config errors.
// - Board status bits 22:9 carry link up, its exit, ticks, hot reset exit, interrupts, sleep exit, lanes.
// - Board status bits 49:23 carry training state, credits, overflow and reset, upper bits zero.
// - Board control bits 31:0 map one for one onto the test control bus.
// - The training state field uses the standard code with all zeros for detect quiet.
`ifndef PCD_CONDUIT_MAP_SVH
`define PCD_CONDUIT_MAP_SVH
// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PCD_REG_CTRL 8'h00
`define PCD_REG_STATE 8'h04
`define PCD_REG_IRQ_STAT 8'h08
`define PCD_REG_IRQ_EN 8'h0C
`define PCD_REG_IRQ_CLR 8'h10
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PCD_TC_FAST 0
`define PCD_TC_NOSCR 2
`define PCD_TC_NOCMPL 5
`define PCD_TC_FORCE 6
`define PCD_TC_NOLP 7
`define PCD_EV_UP 0
`define PCD_EV_DOWN 1
`define PCD_EV_CMPL 2
`define PCD_EV_ERR 3
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PCD_STAT_RST 50'h2000000000000
`define PCD_EN_RST 4'h0
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PCD_CLK_MHZ 40
`define PCD_TICK_NS 128
`define PCD_TICK_US 1
`define PCD_QUIET_MS 12
`define PCD_POLL_MS 24
`define PCD_FAST_SHIFT 6
`define PCD_NS_CYC ((`PCD_TICK_NS * `PCD_CLK_MHZ) / 1000)
`define PCD_US_CYC (`PCD_TICK_US * `PCD_CLK_MHZ)
`endif

// [rtl/pcd_pkg.sv]
// Purpose: types of the test and debug conduit.
// Assumes: nothing beyond the constants header.
// Notes: training state codes follow the standard encoding.
package pcd_pkg;
  // gray steps along quiet, active, configuration
  typedef enum logic [4:0] {
    PCD_QUIET = 5'h00,
    PCD_POLL = 5'h01,
    PCD_CMPL = 5'h03,
    PCD_CFG = 5'h05,
    PCD_L0 = 5'h0F
  } pcd_state_t;

  typedef struct packed {
    pcd_state_t st;
    logic [19:0] cnt;
    logic [2:0] ns_cnt;
    logic [5:0] us_cnt;
    logic [1:0] speed;
    logic scr_en;
    logic lp_en;
    logic fast;
    logic sel;
    logic [49:0] stat;
    logic [3:0] ev;
    logic [3:0] ev_en;
    logic irq;
    logic [31:0] rdata;
  } pcd_regs_t;
endpackage

// [rtl/pcd_conduit.sv]
// Purpose: test and debug conduit: test control decode, a small training
//   sequencer, speed report, packed board status and a register port.
// Assumes: every input is a level synchronous to ref_clk_i.
// Notes: board control may replace the test bus, picked by a control bit.
`timescale 1ns/1ps
`include "pcd_conduit_map.svh"
module pcd_conduit #(
  parameter int QUIET_CYC = `PCD_QUIET_MS * `PCD_CLK_MHZ * 1000,
  parameter int POLL_CYC = `PCD_POLL_MS * `PCD_CLK_MHZ * 1000
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] test_ctrl_i,
  input wire logic [255:0] board_ctrl_i,
  input wire logic rx_detect_i,
  input wire logic [3:0] lane_exit_i,
  input wire logic cfg_done_i,
  input wire logic link_down_i,
  input wire logic [1:0] rate_i,
  input wire logic err_cor_rcv_i,
  input wire logic err_cor_rpl_i,
  input wire logic err_unc_i,
  input wire logic rx_par_err_i,
  input wire logic [1:0] tx_par_err_i,
  input wire logic cfg_par_err_i,
  input wire logic hot_reset_exit_i,
  input wire logic [3:0] int_state_i,
  input wire logic deep_sleep_exit_i,
  input wire logic [3:0] lanes_active_i,
  input wire logic [7:0] completion_header_credits_i,
  input wire logic [11:0] completion_data_credits_i,
  input wire logic cpl_ovf_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic [1:0] current_speed_o,
  output logic [255:0] board_status_o,
  output logic scramble_en_o,
  output logic low_power_en_o,
  output logic fast_init_o
);
  import pcd_pkg::*;

  localparam pcd_regs_t RST = '{st: PCD_QUIET, scr_en: 1'b1, stat: `PCD_STAT_RST,
                                 ev_en: `PCD_EN_RST, default: '0};
  localparam logic [2:0] NS_LAST = 3'(`PCD_NS_CYC - 1);
  localparam logic [5:0] US_LAST = 6'(`PCD_US_CYC - 1);

  // the counter is 20 bits wide; longer waits cannot be served
  if (QUIET_CYC < 1 || QUIET_CYC >= (1 << 20) || POLL_CYC < 1 || POLL_CYC >= (1 << 20)) begin : g_chk
    $error("pcd_conduit: wait counts must fit in 20 bits");
  end

  pcd_regs_t q;
  pcd_regs_t d;
  logic [31:0] ctl;
  logic t_ns;
  logic t_us;
  logic tmo;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // simulation mode divides every initialization wait
  function automatic logic [19:0] pcd_target(input logic fast, input int cyc);
    logic [19:0] full;
    full = 20'(cyc);
    return fast ? (full >> `PCD_FAST_SHIFT) : full;
  endfunction

  // rate 00, 01, 1x maps to speed codes 01, 10, 11
  function automatic logic [1:0] pcd_speed(input logic [1:0] rate);
    return rate[1] ? 2'h3 : (rate[0] ? 2'h2 : 2'h1);
  endfunction

  // ----------------------------------------------------------------------------
  // control source
  // ----------------------------------------------------------------------------
  // board switches stand in for the test bus bit for bit; the upper board
  // control bits have no function and are not looked at
  assign ctl = q.sel ? board_ctrl_i[31:0] : test_ctrl_i;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d = q;
    t_ns = (q.ns_cnt == NS_LAST);
    t_us = (q.us_cnt == US_LAST);
    tmo = (q.cnt >= pcd_target(q.fast, POLL_CYC));
    ev_clr = (wr_i && addr_i == `PCD_REG_IRQ_CLR) ? wdata_i[3:0] : 4'h0;
    // free-running ticks
    d.ns_cnt = t_ns ? 3'h0 : q.ns_cnt + 3'h1;
    d.us_cnt = t_us ? 6'h00 : q.us_cnt + 6'h01;
    // wait counter saturates so a long stall cannot wrap into a false timeout
    d.cnt = (&q.cnt) ? q.cnt : q.cnt + 20'h1;
    d.lp_en = !ctl[`PCD_TC_NOLP];
    // training sequencer
    case (q.st)
      PCD_QUIET: begin
        // the scramble and speed-up choices are taken while initializing
        d.scr_en = !ctl[`PCD_TC_NOSCR];
        d.fast = ctl[`PCD_TC_FAST];
        if (rx_detect_i && q.cnt >= pcd_target(ctl[`PCD_TC_FAST], QUIET_CYC)) begin
          d.st = PCD_POLL;
          d.cnt = '0;
        end
      end
      PCD_POLL: begin
        if (&lane_exit_i) begin
          d.st = PCD_CFG;
          d.cnt = '0;
        end else if (tmo) begin
          // bit 5 beats bit 6: compliance stays barred while it is set
          d.st = (ctl[`PCD_TC_FORCE] && !ctl[`PCD_TC_NOCMPL]) ? PCD_CMPL : PCD_QUIET;
          d.cnt = '0;
        end
      end
      PCD_CMPL: begin
        if (ctl[`PCD_TC_NOCMPL]) begin
          d.st = PCD_QUIET;
          d.cnt = '0;
        end
      end
      PCD_CFG: begin
        if (cfg_done_i) begin
          d.st = PCD_L0;
        end
      end
      PCD_L0: begin
        if (link_down_i) begin
          d.st = PCD_QUIET;
          d.cnt = '0;
        end
      end
      default: begin
        d.st = PCD_QUIET;
        d.cnt = '0;
      end
    endcase
    // speed is only defined while the link is up
    d.speed = (d.st == PCD_L0) ? pcd_speed(rate_i) : 2'h0;
    // events
    ev_set[`PCD_EV_UP] = (d.st == PCD_L0) && (q.st != PCD_L0);
    ev_set[`PCD_EV_DOWN] = (q.st == PCD_L0) && (d.st != PCD_L0);
    ev_set[`PCD_EV_CMPL] = (d.st == PCD_CMPL) && (q.st != PCD_CMPL);
    ev_set[`PCD_EV_ERR] = err_unc_i | rx_par_err_i | (|tx_par_err_i) | cfg_par_err_i;
    // set wins over a clear in the same cycle
    d.ev = (q.ev & ~ev_clr) | ev_set;
    // packed board status
    d.stat = {1'b0, cpl_ovf_i, completion_data_credits_i, completion_header_credits_i,
              d.st,
              lanes_active_i, deep_sleep_exit_i, int_state_i, hot_reset_exit_i,
              t_us, t_ns, ev_set[`PCD_EV_DOWN], d.st == PCD_L0,
              cfg_par_err_i, tx_par_err_i, rx_par_err_i, err_unc_i,
              err_cor_rpl_i, err_cor_rcv_i, d.speed};
    // register writes
    if (wr_i && addr_i == `PCD_REG_CTRL) begin
      d.sel = wdata_i[0];
    end
    if (wr_i && addr_i == `PCD_REG_IRQ_EN) begin
      d.ev_en = wdata_i[3:0];
    end
    d.irq = |(d.ev & d.ev_en);
    // read data stands for the one cycle after the strobe, zero otherwise
    d.rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        `PCD_REG_CTRL: d.rdata = {31'h0, q.sel};
        `PCD_REG_STATE: d.rdata = {22'h0, q.fast, q.lp_en, q.scr_en, q.speed, q.st};
        `PCD_REG_IRQ_STAT: d.rdata = {28'h0, q.ev};
        `PCD_REG_IRQ_EN: d.rdata = {28'h0, q.ev_en};
        default: d.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  // synchronous reset; the core reset flag in the status reads 1 meanwhile
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign rdata_o = q.rdata;
  assign irq_o = q.irq;
  assign current_speed_o = q.speed;
  assign board_status_o = {206'h0, q.stat};
  assign scramble_en_o = q.scr_en;
  assign low_power_en_o = q.lp_en;
  assign fast_init_o = q.fast;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // speed is undefined outside the up state
  a_speed_off_link: assert property (q.st != PCD_L0 |-> current_speed_o == 2'h0)
    else $error("speed reported while link is not up");
  // speed follows the rate seen one cycle earlier
  a_speed_code: assert property ($past(q.st) == PCD_L0 && q.st == PCD_L0 |->
    current_speed_o == pcd_speed($past(rate_i)))
    else $error("speed code does not match rate");
  // status speed field tracks the speed output
  a_status_speed: assert property (board_status_o[1:0] == current_speed_o)
    else $error("status speed field differs");
  // error flags are packed one cycle after their cause; the reset edge loads zeros instead
  a_status_errs: assert property ($past(rst_n_i) |-> board_status_o[8:4] ==
    $past({cfg_par_err_i, tx_par_err_i, rx_par_err_i, err_unc_i}))
    else $error("status error fields wrong");
  // link up flag follows the up state
  a_status_up: assert property (board_status_o[9] == (q.st == PCD_L0))
    else $error("link up flag wrong");
  // the 1 us tick is one cycle long with a long gap after it
  a_tick_gap: assert property ($rose(board_status_o[12]) |=> !board_status_o[12] [*8])
    else $error("microsecond tick repeats too soon");
  // training field carries the state
  a_train_field: assert property (board_status_o[27:23] == q.st)
    else $error("training state field wrong");
  // training field starts in detect quiet after reset
  a_train_reset: assert property ($past(!rst_n_i) |-> board_status_o[27:23] == 5'h00)
    else $error("training state field not quiet after reset");
  // bit 5 keeps compliance away
  a_no_cmpl: assert property (ctl[`PCD_TC_NOCMPL] |=> q.st != PCD_CMPL)
    else $error("compliance entered while barred");
  // forced compliance on a polling timeout
  a_force_cmpl: assert property (q.st == PCD_POLL && tmo && !(&lane_exit_i) &&
    ctl[`PCD_TC_FORCE] && !ctl[`PCD_TC_NOCMPL] |=> q.st == PCD_CMPL)
    else $error("forced compliance missed");
  // scrambling off when requested during initialization
  a_scr_off: assert property (q.st == PCD_QUIET && ctl[`PCD_TC_NOSCR] |=> !scramble_en_o)
    else $error("scrambling not disabled");
  // low power negotiation disabled by bit 7
  a_lp_off: assert property (ctl[`PCD_TC_NOLP] |=> !low_power_en_o)
    else $error("low power negotiation not disabled");
  // fast wait ends the quiet state early
  a_fast_quiet: assert property (q.st == PCD_QUIET && ctl[`PCD_TC_FAST] && rx_detect_i &&
    q.cnt == (20'(QUIET_CYC) >> `PCD_FAST_SHIFT) |=> q.st == PCD_POLL)
    else $error("shortened quiet wait not honoured");
  // board control replaces the test bus when selected
  a_mirror: assert property (q.sel && board_ctrl_i[`PCD_TC_NOLP] |=> !low_power_en_o)
    else $error("board control not mirrored");
endmodule // pcd_conduit

// [bench/pcd_far_model.sv]
// Purpose: far side of the training link: receiver, lanes and configuration peer.
// Assumes: state_i is the training state field of the board status bus.
// Notes: lane_ok_i low withholds the lane exits so that polling times out.
`timescale 1ns/1ps
module pcd_far_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] state_i,
  input wire logic lane_ok_i,
  output logic rx_detect_o,
  output logic [3:0] lane_exit_o,
  output logic cfg_done_o
);
  // ----------------------------------------------------------------------------
  // peer reactions
  // ----------------------------------------------------------------------------
  // levels change only on the core clock edge, never mid cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_detect_o <= 1'b0;
      lane_exit_o <= 4'h0;
      cfg_done_o <= 1'b0;
    end else begin
      rx_detect_o <= (state_i == 5'h00);
      lane_exit_o <= (state_i == 5'h01 && lane_ok_i) ? 4'hF : 4'h0;
      cfg_done_o <= (state_i == 5'h05);
    end
  end
endmodule // pcd_far_model

// [bench/testbench.sv]
// Purpose: self-checking bench of the test and debug conduit.
// Assumes: shortened quiet and polling counts.
// Notes: each scenario is one task; expectations come from the bit map.
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst_n = 1'b0, lane_ok = 1'b1, link_down = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [31:0] tc = 32'h0000_0189, wdata = 32'h0, rdata;
  logic [255:0] bc = 256'h0, bstat;
  logic [37:0] misc = 38'h0;
  logic [7:0] addr = 8'h00;
  logic [1:0] rate = 2'h0, speed;
  logic [3:0] lexit;
  logic rxd, cdone, irq, scr, lp, fast;
  int miscompares = 0, checks_done = 0;
  // ----------------------------------------------------------------------------
  // clock, block and peer
  // ----------------------------------------------------------------------------
  // 40 MHz core clock
  always #12.5 ref_clk = ~ref_clk;
  pcd_conduit #(.QUIET_CYC(64), .POLL_CYC(128)) i_pcd_conduit (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .test_ctrl_i(tc), .board_ctrl_i(bc), .rx_detect_i(rxd), .lane_exit_i(lexit), .cfg_done_i(cdone),
    .link_down_i(link_down), .rate_i(rate), .err_cor_rcv_i(misc[0]), .err_cor_rpl_i(misc[1]),
    .err_unc_i(misc[2]), .rx_par_err_i(misc[3]), .tx_par_err_i(misc[5:4]), .cfg_par_err_i(misc[6]),
    .hot_reset_exit_i(misc[7]), .int_state_i(misc[11:8]), .deep_sleep_exit_i(misc[12]),
    .lanes_active_i(misc[16:13]), .completion_header_credits_i(misc[24:17]),
    .completion_data_credits_i(misc[36:25]), .cpl_ovf_i(misc[37]), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .current_speed_o(speed), .board_status_o(bstat),
    .scramble_en_o(scr), .low_power_en_o(lp), .fast_init_o(fast));
  pcd_far_model i_pcd_far_model (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .state_i(bstat[27:23]),
    .lane_ok_i(lane_ok), .rx_detect_o(rxd), .lane_exit_o(lexit), .cfg_done_o(cdone));
  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a; rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // bounded wait for a training state; running out ends the run
  task automatic wait_st(input logic [4:0] s);
    int n;
    for (n = 0; n < 2000 && bstat[27:23] !== s; n++) tick(1);
    if (n == 2000) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, bstat[27:23], s);
      wrap_up();
    end
  endtask
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic s_reset(input logic [31:0] ctl);
    @(posedge ref_clk);
    rst_n <= 1'b0; tc <= ctl;
    tick(1);
    chk({scr, bstat[49], bstat[27:23], rdata, irq}, {1'b1, 1'b1, 5'h00, 32'h0, 1'b0});
    @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic s_bringup();
    int r;
    lane_ok <= 1'b1;
    wait_st(5'h01);
    wait_st(5'h05);
    wait_st(5'h0F);
    tick(2);
    chk({fast, lp, scr, bstat[9]}, 4'b1011);
    for (r = 0; r < 4; r++) begin
      rate <= r[1:0];
      tick(3);
      chk({speed, bstat[1:0]}, {2{r[1] ? 2'h3 : r[1:0] + 2'h1}});
    end
    rate <= 2'h1;
    rd_chk(8'h04, 32'h0000_02CF);
    rd_chk(8'h08, 32'h1);
    wr_reg(8'h0C, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    wr_reg(8'h0C, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    wr_reg(8'h0C, 32'h1);
    wr_reg(8'h10, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    rd_chk(8'h14, 32'h0);
    lane_ok <= 1'b0;
    link_down <= 1'b1;
    wait_st(5'h00);
    chk(bstat[10], 1'b1);
    link_down <= 1'b0;
    rd_chk(8'h08, 32'h2);
  endtask
  task automatic s_board_ctrl();
    bc <= {224'h0, 32'h0000_0109};
    wr_reg(8'h00, 32'h1);
    tick(3);
    chk(lp, 1'b1);
    rd_chk(8'h00, 32'h1);
    wr_reg(8'h00, 32'h0);
    tick(3);
    chk(lp, 1'b0);
  endtask
  task automatic s_compliance();
    int n, hit;
    s_reset(32'h0000_01CD);
    lane_ok <= 1'b0;
    wait_st(5'h03);
    chk(scr, 1'b0);
    rd_chk(8'h08, 32'h4);
    tc <= 32'h0000_01ED;
    wait_st(5'h00);
    hit = 0;
    for (n = 0; n < 600; n++) begin
      tick(1);
      if (bstat[27:23] === 5'h03) hit++;
    end
    chk(hit, 0);
  endtask
  task automatic s_pack();
    int k, n, t0, t1;
    for (k = 0; k < 2; k++) begin
      misc <= k ? ~38'h25A5A5A5A5 : 38'h25A5A5A5A5;
      tick(2);
      chk({bstat[8:2], bstat[22:13]}, {misc[6:0], misc[16:7]});
      chk(bstat[48:28], misc[37:17]);
      chk(|bstat[255:49], 1'b0);
    end
    rd_chk(8'h08, 32'hC);
    t0 = 0;
    t1 = 0;
    for (n = 0; n < 40; n++) begin
      tick(1);
      t0 += bstat[11];
      t1 += bstat[12];
    end
    chk({t0, t1}, {32'd8, 32'd1});
  endtask
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    s_reset(32'h0000_0189);
    s_bringup();
    s_board_ctrl();
    s_compliance();
    s_pack();
    wrap_up();
  end
endmodule // testbench
